// >>> fwg_regs.svh
// Constants for the flash write/erase guard: register offsets, fields, key values.
// Assumes inclusion by bare name from the package and both ends.
`ifndef FWG_REGS_SVH
`define FWG_REGS_SVH

`define FWG_ADDR_CTRL        8'h8F
`define FWG_ADDR_KEY         8'hB6
`define FWG_CTRL_RESET       8'h00
`define FWG_KEY_RESET        8'h00
`define FWG_BIT_SCRATCH      2
`define FWG_BIT_ERASE_EN     1
`define FWG_BIT_WRITE_EN     0
`define FWG_KEY_FIRST        8'hA5
`define FWG_KEY_SECOND       8'hF1
`define FWG_CODE_LOCKED      2'h0
`define FWG_CODE_KEY1        2'h1
`define FWG_CODE_UNLOCKED    2'h2
`define FWG_CODE_DISABLED    2'h3
`define FWG_SCRATCH_TOP      16'h03FF

`endif

// >>> fwg_pkg.sv
// Types shared by both ends of the flash write/erase guard.
// Assumes fwg_regs.svh is on the include path.
`include "fwg_regs.svh"

package fwg_pkg;

  typedef enum logic [3:0] {
    LK_LOCKED   = 4'b0001,
    LK_KEY1     = 4'b0010,
    LK_UNLOCKED = 4'b0100,
    LK_DISABLED = 4'b1000
  } fwg_lock_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b01,
    OP_BUSY = 2'b10
  } fwg_op_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } fwg_hstate_t;

  typedef enum logic [1:0] {
    CMD_SFR_WR  = 2'h0,
    CMD_SFR_RD  = 2'h1,
    CMD_MOVX_WR = 2'h2,
    CMD_MOVC_RD = 2'h3
  } fwg_cmd_t;

  typedef struct packed {
    logic        scratchpad_select;
    logic        page_erase_enable;
    logic        flash_write_enable;
    fwg_lock_t   lock;
    fwg_op_t     op;
    logic [7:0]  sfr_rdata;
    logic        sfr_rvalid;
    logic        movx_ack;
    logic [7:0]  movc_rdata;
    logic        movc_rvalid;
    logic        flash_prog;
    logic        flash_erase;
    logic        flash_rd;
    logic        flash_scratch;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        xram_wr;
    logic        flash_err_reset;
  } fwg_dev_st_t;

  typedef struct packed {
    fwg_hstate_t st;
    logic        scratchpad_select_shadow;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        cmd_refused;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic        movx_wr;
    logic        movc_rd;
    logic [15:0] mem_addr;
    logic [7:0]  movx_wdata;
  } fwg_host_st_t;

endpackage : fwg_pkg

// >>> fwg_if.sv
// Link between the processor core and the flash guard.
// Assumes one clock shared by both ends; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

interface fwg_if;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        sfr_rvalid;
  logic        movx_wr;
  logic        movc_rd;
  logic [15:0] mem_addr;
  logic [7:0]  movx_wdata;
  logic        movx_ack;
  logic [7:0]  movc_rdata;
  logic        movc_rvalid;

  modport dev (
    input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, movx_wr, movc_rd, mem_addr, movx_wdata,
    output sfr_rdata, sfr_rvalid, movx_ack, movc_rdata, movc_rvalid
  );

  modport host (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, movx_wr, movc_rd, mem_addr, movx_wdata,
    input  sfr_rdata, sfr_rvalid, movx_ack, movc_rdata, movc_rvalid
  );
endinterface : fwg_if

`default_nettype wire

// >>> fwg_host.sv
// Core-side end: turns user commands into link strobes and waits for answers.
// Assumes one command in flight; the guard answers every register read and data write, and register writes are answered here.
`timescale 1ns/1ps
`default_nettype none
`include "fwg_regs.svh"

module fwg_host (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // Link to the guard
  fwg_if.host                  bus,
  // User command side
  input  wire logic            cmd_valid,
  input  wire fwg_pkg::fwg_cmd_t cmd_kind,
  input  wire logic [15:0]     cmd_addr,
  input  wire logic [7:0]      cmd_data,
  output var  logic            cmd_ready,
  output var  logic            cmd_refused,
  output var  logic            rsp_valid,
  output var  logic [7:0]      rsp_data
);
  import fwg_pkg::*;

  fwg_host_st_t q;
  fwg_host_st_t d;

  always_comb
  begin
    d             = q;
    d.sfr_wr      = 1'b0;
    d.sfr_rd      = 1'b0;
    d.movx_wr     = 1'b0;
    d.movc_rd     = 1'b0;
    d.rsp_valid   = 1'b0;
    d.cmd_refused = 1'b0;
    unique case (q.st)
      HS_IDLE:
      begin
        if (cmd_valid && q.cmd_ready)
        begin
          d.mem_addr = cmd_addr;
          if ((cmd_kind == CMD_MOVX_WR || cmd_kind == CMD_MOVC_RD) && q.scratchpad_select_shadow &&
              cmd_addr > `FWG_SCRATCH_TOP)
          begin
            d.cmd_refused = 1'b1;
          end
          else
          begin
            unique case (cmd_kind)
              CMD_SFR_WR:
              begin
                d.sfr_wr    = 1'b1;
                d.sfr_addr  = cmd_addr[7:0];
                d.sfr_wdata = cmd_data;
                d.rsp_valid = 1'b1;
                d.rsp_data  = 8'h00;
                if (cmd_addr[7:0] == `FWG_ADDR_CTRL)
                  d.scratchpad_select_shadow = cmd_data[`FWG_BIT_SCRATCH];
              end
              CMD_SFR_RD:
              begin
                d.sfr_rd    = 1'b1;
                d.sfr_addr  = cmd_addr[7:0];
                d.st        = HS_WAIT;
                d.cmd_ready = 1'b0;
              end
              CMD_MOVX_WR:
              begin
                d.movx_wr    = 1'b1;
                d.movx_wdata = cmd_data;
                d.st         = HS_WAIT;
                d.cmd_ready  = 1'b0;
              end
              CMD_MOVC_RD:
              begin
                d.movc_rd   = 1'b1;
                d.st        = HS_WAIT;
                d.cmd_ready = 1'b0;
              end
            endcase
          end
        end
      end
      HS_WAIT:
      begin
        if (bus.sfr_rvalid || bus.movx_ack || bus.movc_rvalid)
        begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = bus.sfr_rvalid ? bus.sfr_rdata :
                        (bus.movc_rvalid ? bus.movc_rdata : 8'h00);
          d.st        = HS_IDLE;
          d.cmd_ready = 1'b1;
        end
      end
      default:
      begin
        d.st        = HS_IDLE;
        d.cmd_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q           <= '0;
      q.st        <= HS_IDLE;
      q.cmd_ready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus.sfr_wr     = q.sfr_wr;
  assign bus.sfr_rd     = q.sfr_rd;
  assign bus.sfr_addr   = q.sfr_addr;
  assign bus.sfr_wdata  = q.sfr_wdata;
  assign bus.movx_wr    = q.movx_wr;
  assign bus.movc_rd    = q.movc_rd;
  assign bus.mem_addr   = q.mem_addr;
  assign bus.movx_wdata = q.movx_wdata;
  assign cmd_ready      = q.cmd_ready;
  assign cmd_refused    = q.cmd_refused;
  assign rsp_valid      = q.rsp_valid;
  assign rsp_data       = q.rsp_data;

endmodule : fwg_host

`default_nettype wire

// >>> fwg_dev.sv
// Flash guard end: control and key registers, lock state, flash command issue.
// Assumes the flash array and supply monitor run on clk and answer each command
// with one flash_done or flash_rvalid pulse.
`timescale 1ns/1ps
`default_nettype none
`include "fwg_regs.svh"

module fwg_dev (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Link from the core
  fwg_if.dev               bus,
  // Supply monitor status
  input  wire logic        supply_mon_en,
  input  wire logic        supply_rst_en,
  // Flash array
  output var  logic        flash_prog,
  output var  logic        flash_erase,
  output var  logic        flash_rd,
  output var  logic        flash_scratch,
  output var  logic [15:0] mem_addr,
  output var  logic [7:0]  mem_wdata,
  input  wire logic        flash_done,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_rvalid,
  // Data memory and reset control
  output var  logic        xram_wr,
  output var  logic        flash_err_reset
);
  import fwg_pkg::*;

  fwg_dev_st_t q;
  fwg_dev_st_t d;

  // Lock state as seen by software
  function automatic logic [1:0] lock_code(input fwg_lock_t lk);
    logic [1:0] c;
    c = `FWG_CODE_LOCKED;
    unique case (lk)
      LK_LOCKED:   c = `FWG_CODE_LOCKED;
      LK_KEY1:     c = `FWG_CODE_KEY1;
      LK_UNLOCKED: c = `FWG_CODE_UNLOCKED;
      LK_DISABLED: c = `FWG_CODE_DISABLED;
      default:     c = `FWG_CODE_DISABLED;
    endcase
    return c;
  endfunction : lock_code

  logic key_wr;
  logic ctrl_wr;

  always_comb
  begin
    key_wr  = bus.sfr_wr && (bus.sfr_addr == `FWG_ADDR_KEY);
    ctrl_wr = bus.sfr_wr && (bus.sfr_addr == `FWG_ADDR_CTRL);

    d                 = q;
    d.sfr_rvalid      = 1'b0;
    d.movx_ack        = 1'b0;
    d.movc_rvalid     = 1'b0;
    d.flash_prog      = 1'b0;
    d.flash_erase     = 1'b0;
    d.flash_rd        = 1'b0;
    d.xram_wr         = 1'b0;
    d.flash_err_reset = 1'b0;

    // Control register: only the three low bits are stored
    if (ctrl_wr)
    begin
      d.scratchpad_select = bus.sfr_wdata[`FWG_BIT_SCRATCH];
      d.page_erase_enable = bus.sfr_wdata[`FWG_BIT_ERASE_EN];
      d.flash_write_enable = bus.sfr_wdata[`FWG_BIT_WRITE_EN];
    end

    // Key sequence
    if (key_wr)
    begin
      unique case (q.lock)
        LK_LOCKED:
        begin
          if (bus.sfr_wdata == `FWG_KEY_FIRST)
            d.lock = LK_KEY1;
          else
            d.lock = LK_DISABLED;
        end
        LK_KEY1:
        begin
          if (bus.sfr_wdata == `FWG_KEY_SECOND)
            d.lock = LK_UNLOCKED;
          else
            d.lock = LK_DISABLED;
        end
        LK_UNLOCKED:
        begin
          d.lock = LK_DISABLED;
        end
        LK_DISABLED:
        begin
          d.lock = LK_DISABLED;
        end
        default:
        begin
          d.lock = LK_DISABLED;
        end
      endcase
    end

    // Register reads; other addresses belong elsewhere and read as zero
    if (bus.sfr_rd)
    begin
      d.sfr_rvalid = 1'b1;
      if (bus.sfr_addr == `FWG_ADDR_CTRL)
        d.sfr_rdata = {5'b0_0000, q.scratchpad_select, q.page_erase_enable, q.flash_write_enable};
      else if (bus.sfr_addr == `FWG_ADDR_KEY)
        d.sfr_rdata = {6'b00_0000, lock_code(q.lock)};
      else
        d.sfr_rdata = 8'h00;
    end

    // Code reads go to the selected sector
    if (bus.movc_rd)
    begin
      d.flash_rd      = 1'b1;
      d.flash_scratch = q.scratchpad_select;
      d.mem_addr      = bus.mem_addr;
    end
    if (flash_rvalid)
    begin
      d.movc_rvalid = 1'b1;
      d.movc_rdata  = flash_rdata;
    end

    unique case (q.op)
      OP_IDLE:
      begin
        if (bus.movx_wr)
        begin
          d.mem_addr  = bus.mem_addr;
          d.mem_wdata = bus.movx_wdata;
          if (!q.flash_write_enable)
          begin
            // Plain data write, erase enable alone has no effect
            d.xram_wr  = 1'b1;
            d.movx_ack = 1'b1;
          end
          else if (q.lock != LK_UNLOCKED)
          begin
            d.lock     = LK_DISABLED;
            d.movx_ack = 1'b1;
          end
          else if (!(supply_mon_en && supply_rst_en))
          begin
            d.flash_err_reset = 1'b1;
            d.lock            = LK_LOCKED;
            d.movx_ack        = 1'b1;
          end
          else
          begin
            d.flash_scratch = q.scratchpad_select;
            d.flash_erase   = q.page_erase_enable;
            d.flash_prog    = !q.page_erase_enable;
            d.op            = OP_BUSY;
          end
        end
      end
      OP_BUSY:
      begin
        if (flash_done)
        begin
          d.op       = OP_IDLE;
          d.movx_ack = 1'b1;
          // A key write in this cycle still wins if it disables the flash
          if (d.lock != LK_DISABLED)
            d.lock = LK_LOCKED;
        end
      end
      default:
      begin
        d.op = OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q      <= '0;
      q.scratchpad_select <= 1'b0;
      q.page_erase_enable <= 1'b0;
      q.flash_write_enable <= 1'b0;
      q.lock <= LK_LOCKED;
      q.op   <= OP_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus.sfr_rdata   = q.sfr_rdata;
  assign bus.sfr_rvalid  = q.sfr_rvalid;
  assign bus.movx_ack    = q.movx_ack;
  assign bus.movc_rdata  = q.movc_rdata;
  assign bus.movc_rvalid = q.movc_rvalid;
  assign flash_prog      = q.flash_prog;
  assign flash_erase     = q.flash_erase;
  assign flash_rd        = q.flash_rd;
  assign flash_scratch   = q.flash_scratch;
  assign mem_addr        = q.mem_addr;
  assign mem_wdata       = q.mem_wdata;
  assign xram_wr         = q.xram_wr;
  assign flash_err_reset = q.flash_err_reset;

endmodule : fwg_dev

`default_nettype wire

// >>> fwg_checker.sv
// Concurrent checks on the core-to-guard link and the guard's flash strobes.
// Assumes tb instantiates it beside the link; one clock, active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "fwg_regs.svh"

module fwg_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Link
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_rvalid,
  input wire logic       movx_wr,
  input wire logic       movx_ack,
  // Guard flash side
  input wire logic       flash_prog,
  input wire logic       flash_erase,
  input wire logic       flash_done,
  input wire logic       xram_wr
);
  logic [2:0] ctl_q;
  logic [1:0] lk_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Shadow of control bits and lock state seen on the link
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl_q <= 3'h0;
      lk_q  <= 2'h0;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `FWG_ADDR_CTRL) ctl_q <= sfr_wdata[2:0];
      if (sfr_wr && sfr_addr == `FWG_ADDR_KEY)
        lk_q <= (lk_q == 2'h0 && sfr_wdata == `FWG_KEY_FIRST) ? 2'h1 :
                (lk_q == 2'h1 && sfr_wdata == `FWG_KEY_SECOND) ? 2'h2 : 2'h3;
      if (movx_wr && ctl_q[0]) lk_q <= (lk_q == 2'h2) ? 2'h0 : 2'h3;
    end
  end

  sequence s_key_rd;
    sfr_rd && sfr_addr == `FWG_ADDR_KEY;
  endsequence
  sequence s_ctl_rd;
    sfr_rd && sfr_addr == `FWG_ADDR_CTRL;
  endsequence
  sequence s_plain_wr;
    movx_wr && !ctl_q[0];
  endsequence

  a_read_answer: assert property (sfr_rd |=> sfr_rvalid)
    else $error("register read not answered");
  a_ctrl_readback: assert property (s_ctl_rd |=> sfr_rdata == {5'h00, ctl_q})
    else $error("control readback wrong");
  a_key_state: assert property (s_key_rd |=> sfr_rdata == {6'h00, $past(lk_q)})
    else $error("lock state readback wrong");
  a_plain_data: assert property (s_plain_wr |=> xram_wr && movx_ack && !flash_prog && !flash_erase)
    else $error("data write reached flash");
  a_locked_refuse: assert property (movx_wr && ctl_q[0] && lk_q != 2'h2
    |=> movx_ack && !flash_prog && !flash_erase)
    else $error("flash operation while locked");
  a_prog_kind: assert property (flash_prog |-> ctl_q[1:0] == 2'b01)
    else $error("program with wrong enables");
  a_erase_kind: assert property (flash_erase |-> ctl_q[1:0] == 2'b11)
    else $error("erase with wrong enables");
  a_done_ack: assert property (flash_done |=> movx_ack)
    else $error("flash done not acknowledged");
  a_op_single: assert property ((flash_prog || flash_erase) |=> !(flash_prog || flash_erase) [*2])
    else $error("repeated flash command");
endmodule : fwg_checker

`default_nettype wire

// >>> tb.sv
// Testbench: core end and guard end joined by the link; flash array modelled here.
// Assumes fwg_regs.svh on the include path and a 100 ns clock.
`timescale 1ns/1ps
`default_nettype none
`include "fwg_regs.svh"

module tb;
  import fwg_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmd_valid = 1'b0;
  fwg_cmd_t    cmd_kind = CMD_SFR_RD;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0]  cmd_data = 8'h00;
  logic        supply_mon_en = 1'b1;
  logic        supply_rst_en = 1'b1;
  logic        flash_done = 1'b0;
  logic        flash_rvalid = 1'b0;
  logic [7:0]  flash_rdata = 8'h00;
  logic        cmd_ready, cmd_refused, rsp_valid, flash_prog, flash_erase, flash_rd;
  logic        flash_scratch, xram_wr, flash_err_reset;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  rsp_data, r;
  logic        rf = 1'b0;
  logic [15:0] last_a = 16'h0000;
  int          num_errors = 0;
  int          total_checks = 0;
  int          lk = 0, ctl = 0, dly = 0;
  int          seen[4] = '{default: 0};
  int          want[4] = '{default: 0};
  logic [7:0]  bad[3] = '{8'h37, 8'h12, `FWG_KEY_FIRST};

  fwg_if i_fwg_if ();
  fwg_host i_fwg_host (.clk, .resetn, .bus(i_fwg_if), .cmd_valid, .cmd_kind, .cmd_addr,
    .cmd_data, .cmd_ready, .cmd_refused, .rsp_valid, .rsp_data);
  fwg_dev i_fwg_dev (.clk, .resetn, .bus(i_fwg_if), .supply_mon_en, .supply_rst_en,
    .flash_prog, .flash_erase, .flash_rd, .flash_scratch, .mem_addr, .mem_wdata,
    .flash_done, .flash_rdata, .flash_rvalid, .xram_wr, .flash_err_reset);
  fwg_checker u_chk (.clk, .resetn, .sfr_wr(i_fwg_if.sfr_wr), .sfr_rd(i_fwg_if.sfr_rd),
    .sfr_addr(i_fwg_if.sfr_addr), .sfr_wdata(i_fwg_if.sfr_wdata),
    .sfr_rdata(i_fwg_if.sfr_rdata), .sfr_rvalid(i_fwg_if.sfr_rvalid),
    .movx_wr(i_fwg_if.movx_wr), .movx_ack(i_fwg_if.movx_ack), .flash_prog, .flash_erase,
    .flash_done, .xram_wr);

  always #50 clk = ~clk;

  // Flash array: counts strobes, finishes after a random delay, scrambles read data
  always @(posedge clk)
  begin
    seen[0] += flash_prog;
    seen[1] += flash_erase;
    seen[2] += xram_wr;
    seen[3] += flash_err_reset;
    flash_done <= #1 (dly == 1);
    if (dly > 0) dly--;
    if (flash_prog | flash_erase) dly = 2 + $urandom % 4;
    flash_rvalid <= #1 flash_rd;
    flash_rdata <= #1 flash_rd ? mem_addr[7:0] ^ 8'h5A : ~flash_rdata;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (exp !== got)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic op(input fwg_cmd_t k, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    cmd_kind = k;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && cmd_refused !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1 n++;
    end
    r = rsp_data;
    rf = cmd_refused;
    if (n == 50) chk("answer wait", 16'h0001, 16'h0000);
    @(posedge clk);
    #1;
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(CMD_SFR_WR, {8'h00, a}, d);
    if (a == `FWG_ADDR_CTRL) ctl = d & 7;
    if (a == `FWG_ADDR_KEY) lk = (lk == 0 && d == `FWG_KEY_FIRST) ? 1 :
                                 (lk == 1 && d == `FWG_KEY_SECOND) ? 2 : 3;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int e;
    e = (a == `FWG_ADDR_CTRL) ? ctl : (a == `FWG_ADDR_KEY) ? lk : 0;
    op(CMD_SFR_RD, {8'h00, a}, 8'h00);
    chk("register read", 16'(e), {8'h00, r});
  endtask : rd

  task automatic mx();
    logic [15:0] a;
    logic [7:0]  w;
    a = ctl[2] ? 16'($urandom % 1024) : 16'($urandom);
    if (ctl[1:0] == 2'b01) a = last_a;
    last_a = a;
    w = 8'($urandom);
    if (!ctl[0]) want[2]++;
    else if (lk != 2) lk = 3;
    else
    begin
      lk = 0;
      if (!(supply_mon_en && supply_rst_en)) want[3]++;
      else want[ctl[1]]++;
    end
    op(CMD_MOVX_WR, a, w);
    chk("write address", a, mem_addr);
    chk("write data", {8'h00, w}, {8'h00, mem_wdata});
    for (int i = 0; i < 4; i++) chk("pulse count", 16'(want[i]), 16'(seen[i]));
  endtask : mx

  task automatic mc();
    logic [15:0] a;
    a = 16'($urandom % 1024);
    op(CMD_MOVC_RD, a, 8'h00);
    chk("code read", {8'h00, a[7:0] ^ 8'h5A}, {8'h00, r});
    chk("sector select", 16'(ctl[2]), {15'h0000, flash_scratch});
  endtask : mc

  task automatic rst();
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    lk = 0;
    ctl = 0;
  endtask : rst

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  initial
  begin
    void'($urandom(16751));
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    rd(`FWG_ADDR_CTRL);
    rd(`FWG_ADDR_KEY);
    rd(8'h20);
    wr(`FWG_ADDR_CTRL, 8'hFF);
    rd(`FWG_ADDR_CTRL);
    for (int m = 0; m < 3; m++)
    begin
      wr(`FWG_ADDR_CTRL, 8'(m * 2));
      mx();
    end
    // Erase then program, main and scratchpad sector
    for (int m = 0; m < 4; m++)
    begin
      wr(`FWG_ADDR_CTRL, 8'({m[1], !m[0], 1'b1}));
      wr(`FWG_ADDR_KEY, `FWG_KEY_FIRST);
      rd(`FWG_ADDR_KEY);
      wr(`FWG_ADDR_KEY, `FWG_KEY_SECOND);
      rd(`FWG_ADDR_KEY);
      mx();
      rd(`FWG_ADDR_KEY);
      mc();
    end
    // Scratchpad selected: accesses above the first kilobyte never reach the link
    op(CMD_MOVX_WR, 16'h0400 + 16'($urandom % 64512), 8'h00);
    chk("refusal", 16'h0001, {15'h0000, rf});
    op(CMD_MOVC_RD, 16'h0400 + 16'($urandom % 64512), 8'h00);
    chk("refusal", 16'h0001, {15'h0000, rf});
    {supply_mon_en, supply_rst_en} = 2'($urandom_range(2));
    wr(`FWG_ADDR_KEY, `FWG_KEY_FIRST);
    wr(`FWG_ADDR_KEY, `FWG_KEY_SECOND);
    mx();
    rd(`FWG_ADDR_KEY);
    {supply_mon_en, supply_rst_en} = 2'b11;
    mx();
    wr(`FWG_ADDR_KEY, `FWG_KEY_FIRST);
    wr(`FWG_ADDR_KEY, `FWG_KEY_SECOND);
    mx();
    rd(`FWG_ADDR_KEY);
    for (int j = 0; j < 3; j++)
    begin
      rst();
      rd(`FWG_ADDR_KEY);
      if (j > 0) wr(`FWG_ADDR_KEY, `FWG_KEY_FIRST);
      if (j > 1) wr(`FWG_ADDR_KEY, `FWG_KEY_SECOND);
      wr(`FWG_ADDR_KEY, bad[j]);
      rd(`FWG_ADDR_KEY);
    end
    wr(`FWG_ADDR_CTRL, 8'h01);
    mx();
    summarize();
  end

  initial
  begin
    #500_000;
    num_errors++;
    summarize();
  end
endmodule : tb

`default_nettype wire
